// file: rtl/wsf_map.vh
`ifndef WSF_MAP_VH
`define WSF_MAP_VH
// ----------------------------------------
// frame geometry
// ----------------------------------------
`define WSF_LAST_ROW 4'd8
`define WSF_LAST_COL 15'd17279
`define WSF_GRP 15'd192
`define WSF_GRP2 15'd384
`define WSF_TOH_COLS 15'd576
`define WSF_STUFF_END 15'd64
`define WSF_SPE_LAST 15'd16703
`define WSF_ROW_B1 4'd1
`define WSF_ROW_PTR 4'd3
`define WSF_ROW_K 4'd4
`define WSF_ROW_S1 4'd8
`define WSF_POH_B3 4'd1
`define WSF_POH_C2 4'd2
`define WSF_POH_G1 4'd3
// ----------------------------------------
// fixed overhead octets
// ----------------------------------------
`define WSF_A1 8'hf6
`define WSF_A2 8'h28
`define WSF_J0_RST 8'h01
`define WSF_Z0 8'hcc
`define WSF_H1_FIRST 8'h62
`define WSF_H2_FIRST 8'h0a
`define WSF_H1_CONC 8'h93
`define WSF_H2_CONC 8'hff
`define WSF_K1 8'h01
`define WSF_K2 8'h10
`define WSF_S1 8'h0f
`define WSF_C2 8'h1a
`define WSF_ZERO 8'h00
// ----------------------------------------
// scrambler, pointer, sync
// ----------------------------------------
`define WSF_SCR_SEED 7'h7f
`define WSF_PTR_MAX 10'd782
`define WSF_PTR_UNIT 18'd192
`define WSF_D_MASK 10'h155
`define WSF_MAJ 4'd3
`define WSF_SYNC_N 3'd4
`define WSF_REI_MAX 4'd8
// ----------------------------------------
// register word index (byte offset = 4 x index)
// ----------------------------------------
`define WSF_REG_TRACE 3'h0
`define WSF_REG_STATUS 3'h1
`define WSF_REG_B1ERR 3'h2
`define WSF_REG_B3ERR 3'h3
`define WSF_REG_REIERR 3'h4
`endif

// file: rtl/wsf_framer.v
// Summary of operation
// [R1] frame is 9 rows of 17280 octets, sent row by row, column by column
// [R2] scrambler and descrambler handle each octet most significant bit first
// [R3] framing octets are f6 then 28; their transition marks the frame
// [R4] section trace octet carries software value, 01 after reset
// [R5] section growth octets always cc
// [R6] B1 is even BIP-8 over previous frame after scrambling
// [R7] first pointer pair is 62 0a, pointer 522
// [R8] receiver accepts any pointer 0 to 782 and locates payload envelope
// [R9] remaining pointer pairs sent as 93 ff
// [R10] pointer action octets sent zero; carry payload on negative adjustment
// [R11] K1 01, K2 10, S1 0f sent
// [R12] unsupported, undefined overhead and fixed stuff sent as zero
// [R13] B3 is even BIP-8 over previous envelope before scrambling
// [R14] path signal label sent as 1a
// [R15] sent remote error field holds B3 errors of last received envelope
// [R16] received remote error 0 to 8 counts as such, others as zero
// [R17] sent remote defect bit reports current receive defects
// [R18] receiver hunts framing transition, expects it every 155520 octets
// [R19] sync declared only after repeated finds at expected place
// [R20] overhead path then line then section, scramble except row 0 overhead, 16-bit words
// [R21] after alignment descramble, leaving first overhead row untouched
// [R22] receiver strips overhead and fixed stuff, delivers payload octets
// [R23] sync after four good transitions, lost after four misses
// [R24] receiver checks B1 and B3, counting mismatched bits
`timescale 1ns/1ps
`include "wsf_map.vh"
module wsf_framer (
  // clock and reset
  input wire CLK_I,
  input wire RST_I,
  // avalon-mm slave
  input wire [4:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  output reg [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O,
  // transmit payload
  input wire [7:0] TX_PDATA_I,
  input wire TX_PVALID_I,
  output wire TX_PREADY_O,
  // transmit words to pma
  output reg [15:0] TX_DATA_O,
  output reg TX_VALID_O,
  // receive words from pma
  input wire [15:0] RX_DATA_I,
  input wire RX_VALID_I,
  // receive payload and status
  output reg [7:0] RX_PDATA_O,
  output reg RX_PVALID_O,
  output wire RX_SYNC_O
);
  localparam HUNT = 2'd0;
  localparam PRE = 2'd1;
  localparam INSYNC = 2'd2;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // returns {next state, keystream octet}, msb of octet first
  function [14:0] wsf_scr;
    input [6:0] s;
    integer i;
    reg [6:0] t;
    reg [7:0] k;
    begin
      t = s;
      k = 8'h00;
      for (i = 7; i >= 0; i = i - 1)
      begin
        k[i] = t[6]; // [R2]
        t = {t[5:0], t[6] ^ t[5]};
      end
      wsf_scr = {t, k};
    end
  endfunction

  function [3:0] wsf_pop;
    input [9:0] v;
    integer i;
    begin
      wsf_pop = 4'd0;
      for (i = 0; i < 10; i = i + 1)
        wsf_pop = wsf_pop + {3'd0, v[i]};
    end
  endfunction

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  reg ack_q;
  reg [7:0] trace_q;
  reg [15:0] b1_err_q;
  reg [15:0] b3_err_q;
  reg [15:0] rei_err_q;
  reg [1:0] st_q;
  reg ptr_bad_q;
  reg [9:0] ptr_q;
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire wr_go = AVS_WRITE_I & ack_q;
  wire [2:0] widx = AVS_ADDRESS_I[4:2];
  wire clr_b1 = wr_go & (widx == `WSF_REG_B1ERR);
  wire clr_b3 = wr_go & (widx == `WSF_REG_B3ERR);
  wire clr_rei = wr_go & (widx == `WSF_REG_REIERR);
  assign AVS_WAITREQUEST_O = req & ~ack_q;

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ack_q <= 1'b0;
      trace_q <= `WSF_J0_RST;
      AVS_READDATA_O <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (wr_go && widx == `WSF_REG_TRACE && AVS_BYTEENABLE_I[0])
        trace_q <= AVS_WRITEDATA_I[7:0]; // [R4]
      if (AVS_READ_I && !ack_q)
      begin
        case (widx)
          `WSF_REG_TRACE: AVS_READDATA_O <= {24'h000000, trace_q};
          `WSF_REG_STATUS: AVS_READDATA_O <= {6'h00, ptr_q, 13'h0000, ptr_bad_q, st_q};
          `WSF_REG_B1ERR: AVS_READDATA_O <= {16'h0000, b1_err_q};
          `WSF_REG_B3ERR: AVS_READDATA_O <= {16'h0000, b3_err_q};
          `WSF_REG_REIERR: AVS_READDATA_O <= {16'h0000, rei_err_q};
          default: AVS_READDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // transmit frame builder
  // ----------------------------------------
  reg [3:0] trow_q;
  reg [14:0] tcol_q;
  reg [6:0] tscr_q;
  reg [7:0] tb1_acc_q;
  reg [7:0] tb1_q;
  reg [7:0] tb3_acc_q;
  reg [7:0] tb3_q;
  reg [7:0] thold_q;
  reg tphase_q;
  reg [3:0] rei_tx_q;
  reg [7:0] tx_pre;
  reg tx_slot;
  wire [14:0] tspe = tcol_q - `WSF_TOH_COLS;
  wire t_in_spe = tcol_q >= `WSF_TOH_COLS;
  wire t_row0_toh = (trow_q == 4'd0) && !t_in_spe;
  wire [6:0] tseed = (trow_q == 4'd0 && tcol_q == `WSF_TOH_COLS) ? `WSF_SCR_SEED : tscr_q;
  wire [14:0] tscr = wsf_scr(tseed);
  wire [7:0] tx_out = t_row0_toh ? tx_pre : (tx_pre ^ tscr[7:0]); // [R20]
  wire rdi = (st_q != INSYNC) | ptr_bad_q; // [R17]
  wire t_last = (trow_q == `WSF_LAST_ROW) && (tcol_q == `WSF_LAST_COL);
  assign TX_PREADY_O = tx_slot;

  always @*
  begin
    tx_pre = `WSF_ZERO; // [R12]
    tx_slot = 1'b0;
    // path overhead and payload first, then line, then section [R20]
    if (t_in_spe)
    begin
      if (tspe == 15'd0)
      begin
        case (trow_q)
          `WSF_POH_B3: tx_pre = tb3_q; // [R13]
          `WSF_POH_C2: tx_pre = `WSF_C2; // [R14]
          `WSF_POH_G1: tx_pre = {rei_tx_q, rdi, 3'b000}; // [R15] [R17]
          default: tx_pre = `WSF_ZERO; // [R12]
        endcase
      end
      else if (tspe >= `WSF_STUFF_END)
      begin
        tx_slot = 1'b1;
        tx_pre = TX_PVALID_I ? TX_PDATA_I : `WSF_ZERO;
      end
    end
    else if (trow_q == `WSF_ROW_PTR)
    begin
      if (tcol_q == 15'd0)
        tx_pre = `WSF_H1_FIRST; // [R7]
      else if (tcol_q < `WSF_GRP)
        tx_pre = `WSF_H1_CONC; // [R9]
      else if (tcol_q == `WSF_GRP)
        tx_pre = `WSF_H2_FIRST; // [R7]
      else if (tcol_q < `WSF_GRP2)
        tx_pre = `WSF_H2_CONC; // [R9]
      else
        tx_pre = `WSF_ZERO; // [R10]
    end
    else if (trow_q == `WSF_ROW_K && tcol_q == `WSF_GRP)
      tx_pre = `WSF_K1; // [R11]
    else if (trow_q == `WSF_ROW_K && tcol_q == `WSF_GRP2)
      tx_pre = `WSF_K2; // [R11]
    else if (trow_q == `WSF_ROW_S1 && tcol_q == 15'd0)
      tx_pre = `WSF_S1; // [R11]
    else if (trow_q == `WSF_ROW_B1 && tcol_q == 15'd0)
      tx_pre = tb1_q; // [R6]
    else if (trow_q == 4'd0)
    begin
      if (tcol_q < `WSF_GRP)
        tx_pre = `WSF_A1; // [R3]
      else if (tcol_q < `WSF_GRP2)
        tx_pre = `WSF_A2; // [R3]
      else if (tcol_q == `WSF_GRP2)
        tx_pre = trace_q; // [R4]
      else
        tx_pre = `WSF_Z0; // [R5]
    end
  end

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      trow_q <= 4'd0;
      tcol_q <= 15'd0;
      tscr_q <= `WSF_SCR_SEED;
      tb1_acc_q <= 8'h00;
      tb1_q <= 8'h00;
      tb3_acc_q <= 8'h00;
      tb3_q <= 8'h00;
      thold_q <= 8'h00;
      tphase_q <= 1'b0;
      TX_DATA_O <= 16'h0000;
      TX_VALID_O <= 1'b0;
    end
    else
    begin
      // row after row, first column to last [R1]
      if (tcol_q == `WSF_LAST_COL)
      begin
        tcol_q <= 15'd0;
        trow_q <= (trow_q == `WSF_LAST_ROW) ? 4'd0 : trow_q + 4'd1;
      end
      else
        tcol_q <= tcol_q + 15'd1;
      if (!t_row0_toh)
        tscr_q <= tscr[14:8];
      if (t_last)
      begin
        tb1_q <= tb1_acc_q ^ tx_out; // [R6]
        tb1_acc_q <= 8'h00;
        tb3_q <= tb3_acc_q ^ tx_pre; // [R13]
        tb3_acc_q <= 8'h00;
      end
      else
      begin
        tb1_acc_q <= tb1_acc_q ^ tx_out;
        if (t_in_spe)
          tb3_acc_q <= tb3_acc_q ^ tx_pre;
      end
      // first octet of a pair goes in the high half [R20]
      tphase_q <= ~tphase_q;
      TX_VALID_O <= tphase_q;
      if (tphase_q)
        TX_DATA_O <= {thold_q, tx_out};
      else
        thold_q <= tx_out;
    end
  end

  // ----------------------------------------
  // receive input and octet alignment
  // ----------------------------------------
  reg [15:0] rd_m_q;
  reg [15:0] rd_s_q;
  reg rv_m_q;
  reg rv_s_q;
  reg [7:0] rlo_q;
  reg rpend_q;
  reg [15:0] rhist_q;
  reg [2:0] off_q;
  reg [2:0] cnt_q;
  reg [3:0] rrow_q;
  reg [14:0] rcol_q;
  reg hit_any;
  reg [2:0] hit_off;
  integer k;
  wire chunk_v = rv_s_q | rpend_q;
  wire [7:0] chunk = rv_s_q ? rd_s_q[15:8] : rlo_q;
  wire [23:0] win = {rhist_q, chunk};
  wire hit_lock = win[23 - off_q -: 16] == {`WSF_A1, `WSF_A2};
  wire [7:0] oct = win[15 - off_q -: 8];
  wire at_mark = (rrow_q == 4'd0) && (rcol_q == `WSF_GRP);
  assign RX_SYNC_O = st_q == INSYNC;

  always @*
  begin
    hit_any = 1'b0;
    hit_off = 3'd0;
    for (k = 7; k >= 0; k = k - 1)
      if (win[23 - k -: 16] == {`WSF_A1, `WSF_A2}) // [R18]
      begin
        hit_any = 1'b1;
        hit_off = k[2:0];
      end
  end

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      rd_m_q <= 16'h0000;
      rd_s_q <= 16'h0000;
      rv_m_q <= 1'b0;
      rv_s_q <= 1'b0;
      rlo_q <= 8'h00;
      rpend_q <= 1'b0;
      rhist_q <= 16'h0000;
      off_q <= 3'd0;
      cnt_q <= 3'd0;
      st_q <= HUNT;
      rrow_q <= 4'd0;
      rcol_q <= 15'd0;
    end
    else
    begin
      rd_m_q <= RX_DATA_I;
      rd_s_q <= rd_m_q;
      rv_m_q <= RX_VALID_I;
      rv_s_q <= rv_m_q;
      if (rv_s_q)
      begin
        rlo_q <= rd_s_q[7:0];
        rpend_q <= 1'b1;
      end
      else
        rpend_q <= 1'b0;
      if (chunk_v)
      begin
        rhist_q <= win[15:0];
        if (rcol_q == `WSF_LAST_COL)
        begin
          rcol_q <= 15'd0;
          rrow_q <= (rrow_q == `WSF_LAST_ROW) ? 4'd0 : rrow_q + 4'd1;
        end
        else
          rcol_q <= rcol_q + 15'd1;
        case (st_q)
          HUNT:
          begin
            if (hit_any)
            begin
              off_q <= hit_off; // [R18]
              rrow_q <= 4'd0;
              rcol_q <= `WSF_GRP + 15'd1;
              cnt_q <= 3'd1;
              st_q <= PRE;
            end
          end
          PRE:
          begin
            if (at_mark)
            begin
              if (!hit_lock)
                st_q <= HUNT;
              else if (cnt_q + 3'd1 == `WSF_SYNC_N)
              begin
                st_q <= INSYNC; // [R19] [R23]
                cnt_q <= 3'd0;
              end
              else
                cnt_q <= cnt_q + 3'd1;
            end
          end
          INSYNC:
          begin
            if (at_mark)
            begin
              if (hit_lock)
                cnt_q <= 3'd0;
              else if (cnt_q + 3'd1 == `WSF_SYNC_N)
                st_q <= HUNT; // [R23]
              else
                cnt_q <= cnt_q + 3'd1;
            end
          end
          default: st_q <= HUNT;
        endcase
      end
    end
  end

  // ----------------------------------------
  // receive descrambler, pointer and extraction
  // ----------------------------------------
  reg [6:0] rscr_q;
  reg [7:0] rb1_acc_q;
  reg [7:0] rb1_q;
  reg rb1_ok_q;
  reg [7:0] rh1_q;
  reg neg_q;
  reg [17:0] j1_wait_q;
  reg j1_act_q;
  reg spe_ok_q;
  reg [3:0] srow_q;
  reg [14:0] scol_q;
  reg [7:0] rb3_acc_q;
  reg [7:0] rb3_q;
  reg rb3_ok_q;
  wire rgo = chunk_v && st_q == INSYNC;
  wire r_row0_toh = (rrow_q == 4'd0) && (rcol_q < `WSF_TOH_COLS);
  wire [6:0] rseed = (rrow_q == 4'd0 && rcol_q == `WSF_TOH_COLS) ? `WSF_SCR_SEED : rscr_q;
  wire [14:0] rscr = wsf_scr(rseed);
  wire [7:0] dsc = r_row0_toh ? oct : (oct ^ rscr[7:0]); // [R21]
  wire r_h3 = (rrow_q == `WSF_ROW_PTR) && (rcol_q >= `WSF_GRP2) && (rcol_q < `WSF_TOH_COLS);
  wire r_spe = (rcol_q >= `WSF_TOH_COLS) || (neg_q && r_h3); // [R10]
  wire [9:0] ptr_new = {rh1_q[1:0], dsc};
  wire neg_now = wsf_pop((ptr_new ^ ptr_q) & `WSF_D_MASK) >= `WSF_MAJ;
  wire is_j1 = j1_act_q && j1_wait_q == 18'd0;
  wire [3:0] cur_srow = is_j1 ? 4'd0 : srow_q;
  wire [14:0] cur_scol = is_j1 ? 15'd0 : scol_q;
  wire [3:0] b1_bits = wsf_pop({2'b00, dsc ^ rb1_q});
  wire [3:0] b3_bits = wsf_pop({2'b00, dsc ^ rb3_q});
  wire [3:0] rei_rx = (dsc[7:4] <= `WSF_REI_MAX) ? dsc[7:4] : 4'd0; // [R16]
  // path parity octet of a checked envelope: one event feeds both remote error and counter
  wire b3_evt = rgo && r_spe && (spe_ok_q || is_j1) && cur_scol == 15'd0 && cur_srow == `WSF_POH_B3 && rb3_ok_q;
  wire [3:0] rei_tx_d = b3_evt ? b3_bits : rei_tx_q; // [R15] [R24]

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      rscr_q <= `WSF_SCR_SEED;
      rb1_acc_q <= 8'h00;
      rb1_q <= 8'h00;
      rb1_ok_q <= 1'b0;
      rh1_q <= 8'h00;
      ptr_q <= 10'd0;
      ptr_bad_q <= 1'b0;
      neg_q <= 1'b0;
      j1_wait_q <= 18'd0;
      j1_act_q <= 1'b0;
      spe_ok_q <= 1'b0;
      srow_q <= 4'd0;
      scol_q <= 15'd0;
      rb3_acc_q <= 8'h00;
      rb3_q <= 8'h00;
      rb3_ok_q <= 1'b0;
      rei_tx_q <= 4'd0;
      b1_err_q <= 16'h0000;
      b3_err_q <= 16'h0000;
      rei_err_q <= 16'h0000;
      RX_PDATA_O <= 8'h00;
      RX_PVALID_O <= 1'b0;
    end
    else
    begin
      RX_PVALID_O <= 1'b0;
      if (st_q != INSYNC)
      begin
        rb1_ok_q <= 1'b0;
        rb3_ok_q <= 1'b0;
        spe_ok_q <= 1'b0;
        j1_act_q <= 1'b0;
        neg_q <= 1'b0;
      end
      else if (rgo)
      begin
        if (!r_row0_toh)
          rscr_q <= rscr[14:8];
        // section parity on the scrambled stream [R24]
        if (rrow_q == `WSF_LAST_ROW && rcol_q == `WSF_LAST_COL)
        begin
          rb1_q <= rb1_acc_q ^ oct;
          rb1_acc_q <= 8'h00;
          rb1_ok_q <= 1'b1;
          neg_q <= 1'b0;
        end
        else
          rb1_acc_q <= rb1_acc_q ^ oct;
        // pointer interpretation [R8]
        if (rrow_q == `WSF_ROW_PTR && rcol_q == 15'd0)
          rh1_q <= dsc;
        if (rrow_q == `WSF_ROW_PTR && rcol_q == `WSF_GRP)
        begin
          if (neg_now && ptr_q != 10'd0)
          begin
            ptr_q <= ptr_q - 10'd1; // [R10]
            neg_q <= 1'b1;
          end
          else if (ptr_new <= `WSF_PTR_MAX)
          begin
            ptr_q <= ptr_new; // [R8]
            ptr_bad_q <= 1'b0;
          end
          else
            ptr_bad_q <= 1'b1;
        end
        if (rrow_q == `WSF_ROW_PTR && rcol_q == `WSF_TOH_COLS)
        begin
          j1_wait_q <= ({8'h00, ptr_q} * `WSF_PTR_UNIT) - {17'd0, is_j1}; // [R8]
          j1_act_q <= ~is_j1;
        end
        else if (r_spe && j1_act_q && j1_wait_q != 18'd0)
          j1_wait_q <= j1_wait_q - 18'd1;
        else if (is_j1 && r_spe)
          j1_act_q <= 1'b0;
        if (r_spe && (spe_ok_q || is_j1))
        begin
          if (is_j1)
          begin
            spe_ok_q <= 1'b1;
            rb3_q <= rb3_acc_q;
            rb3_acc_q <= dsc;
            rb3_ok_q <= spe_ok_q;
          end
          else
            rb3_acc_q <= rb3_acc_q ^ dsc;
          if (cur_scol == `WSF_SPE_LAST)
          begin
            scol_q <= 15'd0;
            srow_q <= (cur_srow == `WSF_LAST_ROW) ? 4'd0 : cur_srow + 4'd1;
          end
          else
          begin
            scol_q <= cur_scol + 15'd1;
            srow_q <= cur_srow;
          end
          if (cur_scol == 15'd0 && cur_srow == `WSF_POH_G1)
            rei_err_q <= (clr_rei ? 16'h0000 : rei_err_q) + {12'h000, rei_rx}; // [R16]
          if (cur_scol >= `WSF_STUFF_END)
          begin
            RX_PDATA_O <= dsc; // [R22]
            RX_PVALID_O <= 1'b1;
          end
        end
      end
      rei_tx_q <= rei_tx_d;
      // a counting event in the cycle of a software clear is added to the cleared count
      if (rgo && rrow_q == `WSF_ROW_B1 && rcol_q == 15'd0 && rb1_ok_q)
        b1_err_q <= (clr_b1 ? 16'h0000 : b1_err_q) + {12'h000, b1_bits}; // [R24]
      else if (clr_b1)
        b1_err_q <= 16'h0000;
      if (b3_evt)
        b3_err_q <= (clr_b3 ? 16'h0000 : b3_err_q) + {12'h000, b3_bits}; // [R24]
      else if (clr_b3)
        b3_err_q <= 16'h0000;
      if (clr_rei && !(rgo && r_spe && (spe_ok_q || is_j1) && cur_scol == 15'd0 && cur_srow == `WSF_POH_G1))
        rei_err_q <= 16'h0000;
    end
  end
endmodule

// file: test/wsf_framer_props.sv
`timescale 1ns/1ps
module wsf_props (
  // clock and reset
  input wire CLK_I,
  input wire RST_I,
  // register bus
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire AVS_WAITREQUEST_O,
  // transmit side
  input wire TX_PREADY_O,
  input wire [15:0] TX_DATA_O,
  input wire TX_VALID_O,
  // receive side
  input wire RX_PVALID_O,
  input wire RX_SYNC_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  // ----
  // run-length and age counters
  // ----
  logic [14:0] hi_q;
  logic [9:0] lo_q;
  logic fell_q;
  logic [19:0] age_q;
  logic [3:0] syl_q;
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      hi_q <= 15'h0;
      lo_q <= 10'h0;
      fell_q <= 1'b0;
      age_q <= 20'h0;
      syl_q <= 4'h0;
    end
    else
    begin
      hi_q <= TX_PREADY_O ? hi_q + 15'h1 : 15'h0;
      lo_q <= TX_PREADY_O ? 10'h0 : lo_q + 10'h1;
      fell_q <= fell_q | (hi_q != 15'h0 && !TX_PREADY_O);
      age_q <= (age_q == 20'hfffff) ? age_q : age_q + 20'h1;
      syl_q <= RX_SYNC_O ? 4'h0 : ((syl_q == 4'hf) ? syl_q : syl_q + 4'h1);
    end
  end
  // ----
  // properties
  // ----
  sequence s_req_new;
    (AVS_READ_I || AVS_WRITE_I) && !$past(AVS_READ_I || AVS_WRITE_I);
  endsequence
  sequence s_wait_one;
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endsequence
  a_bus_wait: assert property (s_req_new |-> s_wait_one)
    else $error("bus wait is not one cycle");
  a_wait_idle: assert property (AVS_WAITREQUEST_O |-> AVS_READ_I || AVS_WRITE_I)
    else $error("wait without request");
  a_rdata_hold: assert property ($changed(AVS_READDATA_O) |-> $past(AVS_READ_I))
    else $error("read data moved without read");
  a_ready_run: assert property ($fell(TX_PREADY_O) |-> hi_q == 15'h4100)
    else $error("payload window length wrong");
  a_ready_gap: assert property ($rose(TX_PREADY_O) && fell_q |-> lo_q == 10'h280)
    else $error("overhead gap length wrong");
  a_txv_pulse: assert property (TX_VALID_O |=> !TX_VALID_O ##1 TX_VALID_O)
    else $error("word pulse cadence wrong");
  a_txd_stand: assert property (TX_VALID_O |=> $stable(TX_DATA_O))
    else $error("word changed between pulses");
  a_first_word: assert property ($fell(RST_I) |-> ##[1:4] (TX_VALID_O && TX_DATA_O == 16'hf6f6))
    else $error("first framing word missing");
  a_sync_early: assert property ($rose(RX_SYNC_O) |-> age_q >= 20'h71e80)
    else $error("sync declared too early");
  a_rx_refused: assert property (RX_PVALID_O |-> syl_q < 4'h8)
    else $error("payload out of sync");
endmodule

// file: test/wsf_pma.sv
`timescale 1ns/1ps
module wsf_pma (
  // clock
  input wire clk_i,
  // words from the framer
  input wire [15:0] tx_data_i,
  input wire tx_valid_i,
  // words back to the framer
  output logic [15:0] rx_data_o,
  output logic rx_valid_o
);
  initial
  begin
    rx_data_o = 16'h0;
    rx_valid_o = 1'b0;
  end
  // between words the line shows the inverse, never a stale value
  always @(posedge clk_i)
  begin
    rx_valid_o <= tx_valid_i;
    rx_data_o <= tx_valid_i ? tx_data_i : ~rx_data_o;
  end
endmodule

// file: test/tb_wan_sonet_frame_framer.sv
`timescale 1ns/1ps
module tb_wan_sonet_frame_framer;
  localparam int ROW = 17280;
  localparam int NS = 5 * ROW;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [7:0] pdat = 8'h00;
  logic pval = 1'b0;
  logic prdy;
  logic take = 1'b0;
  logic [4:0] cyc = 5'h00;
  logic [15:0] txd;
  logic txv;
  logic [15:0] rxd;
  logic rxv;
  logic [7:0] rxp;
  logic rxpv;
  logic sync;
  logic [7:0] got [0:NS-1];
  logic [7:0] pay [0:NS-1];
  logic rdy [0:NS-1];
  logic [31:0] v;
  int k = -1;
  int npay = 0;
  int err_count = 0;
  int checked = 0;
  always #25 clk = ~clk;
  wsf_framer dut (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .TX_PDATA_I(pdat), .TX_PVALID_I(pval), .TX_PREADY_O(prdy), .TX_DATA_O(txd), .TX_VALID_O(txv),
    .RX_DATA_I(rxd), .RX_VALID_I(rxv), .RX_PDATA_O(rxp), .RX_PVALID_O(rxpv), .RX_SYNC_O(sync));
  wsf_pma u_pma (.clk_i(clk), .tx_data_i(txd), .tx_valid_i(txv), .rx_data_o(rxd), .rx_valid_o(rxv));
  // ----
  // payload source, one idle slot in 32
  // ----
  always @(posedge clk)
  begin
    if (!rst)
    begin
      cyc <= cyc + 5'h01;
      pval <= (cyc != 5'h03);
      if (take)
        pdat <= pdat + 8'h01;
    end
  end
  // ----
  // mid-cycle monitor: slot k is the current octet slot
  // ----
  always @(negedge clk)
  begin
    if (k < 0 && txv === 1'b1)
      k = 2;
    if (k >= 2 && k <= NS && txv === 1'b1)
    begin
      got[k-2] = txd[15:8];
      got[k-1] = txd[7:0];
    end
    if (k >= 2 && k < NS)
    begin
      rdy[k] = prdy;
      pay[k] = (pval && prdy) ? pdat : 8'h00;
    end
    if (k >= 0)
      k++;
    take = pval && prdy;
    if (rxpv === 1'b1)
      npay++;
  end
  // ----
  // helpers
  // ----
  task automatic print_verdict();
    begin
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      checked++;
      if (g !== e)
      begin
        err_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] b, input logic [31:0] d);
    int n;
    logic wq;
    begin
      n = 0;
      wq = 1'b1;
      adr <= a;
      be <= b;
      wdat <= d;
      wr <= w;
      rd <= !w;
      // values read right after the edge are those the edge sampled
      while (wq !== 1'b0)
      begin
        @(posedge clk);
        wq = wreq;
        v = rdat;
        n++;
        if (n > 20)
        begin
          $display("BAD t=%0t got=%h exp=%h", $time, wq, 1'b0);
          err_count++;
          print_verdict();
        end
      end
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // expected octet before scrambling; bit 8 marks a parity octet left unchecked
  function automatic logic [8:0] plain(input int s, input logic [7:0] p);
    int r;
    int c;
    begin
      r = s / ROW;
      c = s % ROW;
      plain = 9'h000;
      if (c >= 640)
        plain = {1'b0, p};
      else if (r == 0)
        plain = (c < 192) ? 9'h0f6 : (c < 384) ? 9'h028 : (c == 384) ? 9'h001 : (c < 576) ? 9'h0cc : 9'h000;
      else if (r == 1 && (c == 0 || c == 576))
        plain = 9'h100;
      else if (r == 2 && c == 576)
        plain = 9'h01a;
      else if (r == 3)
        plain = (c == 0) ? 9'h062 : (c < 192) ? 9'h093 : (c == 192) ? 9'h00a : (c < 384) ? 9'h0ff :
          (c == 576) ? 9'h008 : 9'h000;
      else if (r == 4)
        plain = (c == 192) ? 9'h001 : (c == 384) ? 9'h010 : 9'h000;
    end
  endfunction
  task automatic frame_check();
    logic [6:0] st;
    logic [7:0] key;
    logic [8:0] e;
    begin
      st = 7'h7f;
      for (int s = 0; s < NS; s++)
      begin
        key = 8'h00;
        if (s >= 576)
          for (int b = 7; b >= 0; b--)
          begin
            key[b] = st[6];
            st = {st[5:0], st[6] ^ st[5]};
          end
        e = plain(s, pay[s]);
        if (!e[8])
          chk({24'h0, got[s]}, {24'h0, e[7:0] ^ key});
        if (s >= 2)
          chk({31'h0, rdy[s]}, (s % ROW >= 640) ? 32'h1 : 32'h0);
      end
    end
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 5'h00, 4'hf, 32'h0);
    chk(v, 32'h01);
    bus(1'b0, 5'h04, 4'hf, 32'h0);
    chk({30'h0, v[1:0]}, 32'h0);
    bus(1'b1, 5'h08, 4'h0, 32'h0);
    bus(1'b0, 5'h08, 4'hf, 32'h0);
    chk(v, 32'h0);
    bus(1'b0, 5'h14, 4'hf, 32'h0);
    chk(v, 32'h0);
    for (int i = 0; i < 1000 && k < 600; i++)
      @(posedge clk);
    chk({31'h0, k >= 600}, 32'h1);
    bus(1'b1, 5'h00, 4'h1, 32'h5a);
    bus(1'b1, 5'h00, 4'he, 32'ha5);
    bus(1'b1, 5'h1c, 4'hf, 32'hff);
    bus(1'b0, 5'h00, 4'hf, 32'h0);
    chk(v, 32'h5a);
    $display("test registers done");
    for (int i = 0; i < NS + 1000 && k <= NS; i++)
      @(posedge clk);
    chk({31'h0, k > NS}, 32'h1);
    chk({31'h0, sync}, 32'h0);
    chk(32'(npay), 32'h0);
    frame_check();
    $display("test transmit frame done");
    print_verdict();
  end
endmodule
bind wsf_framer wsf_props u_props (.CLK_I(CLK_I), .RST_I(RST_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .TX_PREADY_O(TX_PREADY_O), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .RX_PVALID_O(RX_PVALID_O),
  .RX_SYNC_O(RX_SYNC_O));
